//--- eats_pkg.sv
// Purpose: Shared types and constants for the effective-address timing sequencer
// Assumes: Core clock mclk at 10 MHz; baseline bus access of two clocks
package eats_pkg;

  localparam logic [3:0] EATS_BASE_BUS_CLKS = 4'h2;
  localparam logic [1:0] EATS_LONG_READS    = 2'h2;
  localparam logic [1:0] EATS_SHORT_READS   = 2'h1;
  localparam logic [7:0] EATS_LONG_ADD      = 8'h02;

  localparam int unsigned EATS_CLK_NS      = 100;
  localparam int unsigned EATS_EXT_HOLD_NS = 100;
  localparam int unsigned EATS_EXT_HOLD_CYC =
    (EATS_EXT_HOLD_NS + EATS_CLK_NS - 1) / EATS_CLK_NS;

  typedef enum logic [4:0] {
    EATS_DN, EATS_AN, EATS_IND, EATS_POSTINC, EATS_PREDEC,
    EATS_D16, EATS_ABSW, EATS_ABSL, EATS_IMMB, EATS_IMMW, EATS_IMML,
    EATS_D8X, EATS_FULL_NONE, EATS_FULL_D16, EATS_FULL_D32,
    EATS_FULL_AN, EATS_FULL_X, EATS_FULL_ANX, EATS_FULL_D16AN,
    EATS_FULL_D32AN, EATS_FULL_D16ANX, EATS_FULL_D32ANX
  } eats_mode_e;

  typedef struct packed {
    logic [4:0]        head;
    logic signed [6:0] tail;
    logic [6:0]        cycles;
    logic [1:0]        reads;
    logic [1:0]        fetches;
    logic [1:0]        writes;
  } eats_fig_s;

  localparam eats_fig_s EATS_FIG_RST = '0;

  typedef struct packed {
    eats_mode_e mode;
    logic       calc;
    logic       long_op;
    logic       base_pc;
    logic [3:0] bus_clks;
    logic       ext_imm;
    logic       ext_long;
  } eats_req_s;

  typedef enum logic [3:0] {
    EATS_IDLE = 4'h1,
    EATS_WAIT = 4'h2,
    EATS_ADJ  = 4'h4,
    EATS_DONE = 4'h8
  } eats_state_e;

endpackage : eats_pkg

//--- eats_rom.sv
// Purpose: Baseline head, tail and clock figures per addressing mode
// Assumes: Two-clock bus, word operand; read count 1 stands for one operand read
// Notes: Purely combinational lookup
`timescale 1ns/10ps
`default_nettype none
module eats_rom
  import eats_pkg::*;
(
  // Lookup
  input  wire eats_mode_e mode,
  input  wire logic       calc,
  // Figures
  output var eats_fig_s   fig
);

  function automatic eats_fig_s mk(input int h, input int t, input int c,
                                   input int r, input int p);
    eats_fig_s f;
    f.head    = 5'(h);
    f.tail    = 7'(t);
    f.cycles  = 7'(c);
    f.reads   = 2'(r);
    f.fetches = 2'(p);
    f.writes  = 2'h0;
    return f;
  endfunction : mk

  // Index size and scale are not inputs at all, so they cannot move a figure
  // Base register or PC share one mode code
  // Calculate rows drop the operand read from tail and total
  always_comb begin
    fig = EATS_FIG_RST;
    case (mode)
      EATS_IND:         fig = calc ? mk(1, 0, 2, 0, 0) : mk(1, 1, 3, 1, 0);
      EATS_POSTINC:     fig = calc ? mk(1, 0, 2, 0, 0) : mk(1, 1, 3, 1, 0);
      EATS_PREDEC:      fig = calc ? mk(2, 0, 2, 0, 0) : mk(2, 2, 4, 1, 0);
      EATS_D16:         fig = calc ? mk(1, 1, 3, 0, 1) : mk(1, 3, 5, 1, 1);
      EATS_ABSW:        fig = calc ? mk(1, 1, 3, 0, 1) : mk(1, 3, 5, 1, 1);
      EATS_ABSL:        fig = calc ? mk(1, 3, 5, 0, 2) : mk(1, 5, 7, 1, 2);
      EATS_IMMB:        fig = mk(1, 1, 3, 0, 1);
      EATS_IMMW:        fig = mk(1, 1, 3, 0, 1);
      EATS_IMML:        fig = mk(1, 3, 5, 0, 2);
      EATS_D8X:         fig = calc ? mk(4, 0, 6, 0, 1) : mk(4, 2, 8, 1, 1);
      EATS_FULL_NONE:   fig = calc ? mk(2, 0, 4, 0, 1) : mk(2, 2, 6, 1, 1);
      EATS_FULL_D16:    fig = calc ? mk(1, 1, 5, 0, 2) : mk(1, 3, 7, 1, 2);
      EATS_FULL_D32:    fig = calc ? mk(1, 3, 7, 0, 3) : mk(1, 5, 9, 1, 3);
      EATS_FULL_AN:     fig = calc ? mk(1, 0, 4, 0, 1) : mk(1, 1, 5, 1, 1);
      EATS_FULL_X:      fig = calc ? mk(4, 0, 6, 0, 1) : mk(4, 2, 8, 1, 1);
      EATS_FULL_ANX:    fig = calc ? mk(4, 0, 6, 0, 1) : mk(4, 2, 8, 1, 1);
      EATS_FULL_D16AN:  fig = calc ? mk(1, 1, 5, 0, 2) : mk(1, 3, 7, 1, 2);
      EATS_FULL_D32AN:  fig = calc ? mk(1, 3, 7, 0, 3) : mk(1, 5, 9, 1, 3);
      EATS_FULL_D16ANX: fig = calc ? mk(2, 0, 6, 0, 2) : mk(2, 2, 8, 1, 2);
      EATS_FULL_D32ANX: fig = calc ? mk(1, 1, 7, 0, 3) : mk(1, 3, 9, 1, 3);
      default:          fig = EATS_FIG_RST;
    endcase
  end

endmodule : eats_rom
`default_nettype wire

//--- eats_adj.sv
// Purpose: Adjust baseline figures for operand length and bus speed
// Assumes: bus_clks is clocks per access, never below two in practice
// Notes: Purely combinational
`timescale 1ns/10ps
`default_nettype none
module eats_adj
  import eats_pkg::*;
(
  // Baseline
  input  wire eats_fig_s  base,
  input  wire logic       long_op,
  input  wire logic [3:0] bus_clks,
  // Adjusted
  output var eats_fig_s   fig
);

  logic [3:0] extra;
  logic [1:0] reads;
  logic [7:0] rd_extra;
  logic [7:0] pf_extra;
  logic [7:0] tail_w;
  logic [7:0] cyc_w;
  logic [7:0] head_w;

  always_comb begin
    extra = (bus_clks > EATS_BASE_BUS_CLKS) ? bus_clks - EATS_BASE_BUS_CLKS : 4'h0;
    reads = base.reads;
    if (base.reads != 2'h0) begin
      reads = long_op ? EATS_LONG_READS : EATS_SHORT_READS;
    end
    rd_extra = 8'(reads) * 8'(extra);
    pf_extra = 8'(base.fetches) * 8'(extra);
    head_w   = 8'(base.head);
    tail_w   = 8'(base.tail) + rd_extra;
    cyc_w    = 8'(base.cycles) + rd_extra;
    if (long_op && (base.reads != 2'h0)) begin
      tail_w = tail_w + EATS_LONG_ADD;
      cyc_w  = cyc_w + EATS_LONG_ADD;
    end
    // Head soaks up slow prefetches first, then the rest spills past it
    if (head_w >= pf_extra) begin
      head_w = head_w - pf_extra;
    end else begin
      tail_w = tail_w + (pf_extra - head_w);
      cyc_w  = cyc_w + (pf_extra - head_w);
      head_w = 8'h00;
    end
    fig         = base;
    fig.reads   = reads;
    fig.head    = head_w[4:0];
    fig.tail    = tail_w[6:0];
    fig.cycles  = cyc_w[6:0];
  end

endmodule : eats_adj
`default_nettype wire

//--- eats_seq.sv
// Purpose: Effective-address timing sequencer top; figures, overlaps and start permits
// Assumes: Decode holds req until req_ready; neighbour head and tail are stable with req
// Notes: One request in flight; report lasts one cycle with rpt_valid
`timescale 1ns/10ps
`default_nettype none
module eats_seq
  import eats_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // Request from decode
  input  wire logic        req_valid,
  input  wire eats_req_s   req,
  output logic             req_ready,
  // Neighbouring operations
  input  wire logic [4:0]  next_head,
  input  wire logic signed [6:0] prev_tail,
  // Extension word presence in the pipe
  input  wire logic        ext_word_valid,
  // Report to the scheduler
  output logic             rpt_valid,
  output var eats_fig_s    rpt,
  output logic             rpt_base_pc,
  output logic [4:0]       ov_prev,
  output logic [4:0]       ov_next,
  output logic [7:0]       total_clks,
  output logic             prefetch_early,
  output logic             ext_wait
);

  eats_state_e state_r;
  eats_state_e state_nxt;

  eats_req_s   req_r;
  logic [4:0]  next_head_r;
  logic signed [6:0] prev_tail_r;

  eats_fig_s   base_fig;
  eats_fig_s   adj_fig;

  logic        ext_held_r;
  logic        ext_need;
  logic        ext_need_in;
  logic        ext_ok;
  logic        take;

  logic [6:0]  prev_pos;
  logic [4:0]  ov_in;
  logic [4:0]  ov_out;
  logic [7:0]  sum_ov;
  logic [7:0]  total_w;

  // Baseline lookup
  eats_rom u_rom (
    .mode (req_r.mode),
    .calc (req_r.calc),
    .fig  (base_fig)
  );

  // Length and bus-speed adjustment
  eats_adj u_adj (
    .base     (base_fig),
    .long_op  (req_r.long_op),
    .bus_clks (req_r.bus_clks),
    .fig      (adj_fig)
  );

  assign take = req_valid && (state_r == EATS_IDLE);

  // Long offsets and displacements never wait for the pipe
  assign ext_need = req_r.ext_imm && !req_r.ext_long;

  // On the take edge the held copy is still the last request's, so look at the live one
  assign ext_need_in = take ? (req.ext_imm && !req.ext_long) : ext_need;

  // Word must have sat one full cycle before start
  assign ext_ok = ext_word_valid && ext_held_r;

  // Next-state logic
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      EATS_IDLE: begin
        if (req_valid) begin
          state_nxt = EATS_WAIT;
        end
      end
      EATS_WAIT: begin
        if (!ext_need || ext_ok) begin
          state_nxt = EATS_ADJ;
        end
      end
      EATS_ADJ: begin
        state_nxt = EATS_DONE;
      end
      EATS_DONE: begin
        state_nxt = EATS_IDLE;
      end
      default: begin
        state_nxt = EATS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= EATS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Request capture
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      req_r       <= '0;
      next_head_r <= 5'h00;
      prev_tail_r <= 7'sh00;
    end else if (take) begin
      req_r       <= req;
      next_head_r <= next_head;
      prev_tail_r <= prev_tail;
    end
  end

  // Ready only while idle; it drops on the edge that takes a request
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      req_ready <= 1'b1;
    end else begin
      req_ready <= (state_nxt == EATS_IDLE);
    end
  end

  // Extension word residency; a drop of the word restarts the count
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ext_held_r <= 1'b0;
    end else if (state_r == EATS_WAIT) begin
      ext_held_r <= ext_word_valid;
    end else begin
      ext_held_r <= 1'b0;
    end
  end

  // Waiting flag for the decode pipeline
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ext_wait <= 1'b0;
    end else begin
      ext_wait <= (state_nxt == EATS_WAIT) && ext_need_in && !ext_ok;
    end
  end

  // Overlap arithmetic
  always_comb begin
    // Negative tails count as zero clocks of write
    prev_pos = prev_tail_r[6] ? 7'h00 : prev_tail_r;
    // Trailing write hides under the head; free when head covers it
    if (prev_pos > 7'(adj_fig.head)) begin
      ov_in = adj_fig.head;
    end else begin
      ov_in = prev_pos[4:0];
    end
    // Read and replacement fetches run under the next head by the tail
    if (next_head_r == 5'h00) begin
      ov_out = 5'h00;
    end else if (adj_fig.tail[6]) begin
      ov_out = 5'h00;
    end else if (7'(next_head_r) > adj_fig.tail) begin
      ov_out = adj_fig.tail[4:0];
    end else begin
      ov_out = next_head_r;
    end
    sum_ov = 8'(ov_in) + 8'(ov_out);
    // Saturate rather than wrap if a neighbour claims more than the total
    if (8'(adj_fig.cycles) > sum_ov) begin
      total_w = 8'(adj_fig.cycles) - sum_ov;
    end else begin
      total_w = 8'h00;
    end
  end

  // Report figures
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rpt <= EATS_FIG_RST;
    end else if (state_r == EATS_ADJ) begin
      rpt <= adj_fig;
    end
  end

  // Report the base choice; figures are the same either way
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rpt_base_pc <= 1'b0;
    end else if (state_r == EATS_ADJ) begin
      rpt_base_pc <= req_r.base_pc;
    end
  end

  // Overlap results
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ov_prev    <= 5'h00;
      ov_next    <= 5'h00;
      total_clks <= 8'h00;
    end else if (state_r == EATS_ADJ) begin
      ov_prev    <= ov_in;
      ov_next    <= ov_out;
      total_clks <= total_w;
    end
  end

  // Early prefetch permit behind a negative tail
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prefetch_early <= 1'b0;
    end else if (take) begin
      prefetch_early <= prev_tail[6];
    end else if (state_r == EATS_DONE) begin
      prefetch_early <= 1'b0;
    end
  end

  // Report strobe, one cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rpt_valid <= 1'b0;
    end else begin
      rpt_valid <= (state_r == EATS_ADJ);
    end
  end

endmodule : eats_seq
`default_nettype wire

//--- eats_seq_asserts.sv
// Purpose: Concurrent checks on the sequencer ports
// Assumes: One request in flight; neighbours latched at take
// Notes: Keeps its own copy of the request, as the design's copy is hidden
`timescale 1ns/10ps
`default_nettype none
module eats_seq_asserts
  import eats_pkg::*;
(
  // Clock and reset
  input wire logic              mclk,
  input wire logic              reset_n,
  // Request side
  input wire logic              req_valid,
  input wire eats_req_s         req,
  input wire logic              req_ready,
  input wire logic [4:0]        next_head,
  input wire logic signed [6:0] prev_tail,
  input wire logic              ext_word_valid,
  // Report side
  input wire logic              rpt_valid,
  input wire eats_fig_s         rpt,
  input wire logic              rpt_base_pc,
  input wire logic [4:0]        ov_prev,
  input wire logic [4:0]        ov_next,
  input wire logic [7:0]        total_clks,
  input wire logic              prefetch_early,
  input wire logic              ext_wait
);
  logic              take;
  eats_req_s         req_r;
  logic [4:0]        nh_r;
  logic signed [6:0] pt_r;
  int                tl, pt, eovp, eovn, etot;

  assign take = req_valid && req_ready;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      req_r <= '0;
      nh_r  <= '0;
      pt_r  <= '0;
    end else if (take) begin
      req_r <= req;
      nh_r  <= next_head;
      pt_r  <= prev_tail;
    end
  end

  // Negative neighbours count as zero overlap
  always_comb begin
    tl   = $signed(rpt.tail);
    pt   = $signed(pt_r);
    eovp = (pt < 0) ? 0 : ((pt < int'(rpt.head)) ? pt : int'(rpt.head));
    eovn = (nh_r == 5'h0 || tl < 0) ? 0 : ((tl < int'(nh_r)) ? tl : int'(nh_r));
    etot = int'(rpt.cycles) - eovp - eovn;
    if (etot < 0) begin
      etot = 0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  ready_drop_a: assert property (take |=> !req_ready)
    else $error("ready stayed high after take");
  no_wait_lat_a: assert property (take && (!req.ext_imm || req.ext_long) |-> ##3 rpt_valid)
    else $error("report late without extension wait");
  ext_hold_a: assert property (ext_wait && !ext_word_valid |=> !rpt_valid [*2])
    else $error("report before extension word settled");
  rpt_pulse_a: assert property (rpt_valid |-> !req_ready ##1 (req_ready && !rpt_valid))
    else $error("report pulse wrong");
  ov_prev_a: assert property (rpt_valid |-> ov_prev == eovp)
    else $error("previous overlap wrong");
  ov_next_a: assert property (rpt_valid |-> ov_next == eovn)
    else $error("next overlap wrong");
  total_sum_a: assert property (rpt_valid |-> total_clks == etot)
    else $error("total clocks wrong");
  early_fetch_a: assert property (take && prev_tail < 0 |=> prefetch_early)
    else $error("early prefetch not allowed");
  calc_read_a: assert property (rpt_valid && req_r.calc |-> rpt.reads == 2'h0)
    else $error("calculate mode reads operand");
  long_read_a: assert property (rpt_valid && req_r.long_op
    && !req_r.calc && rpt.reads != 2'h0 |-> rpt.reads == 2'h2)
    else $error("long operand read count wrong");
  base_pc_a: assert property (rpt_valid |-> rpt_base_pc == req_r.base_pc)
    else $error("base echo wrong");

  cover property (take && req.ext_imm && !req.ext_long);
  cover property (rpt_valid && req_r.calc);
  cover property (take && prev_tail < 0);
endmodule : eats_seq_asserts

bind eats_seq eats_seq_asserts eats_seq_asserts_inst (
  .mclk(mclk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .next_head(next_head), .prev_tail(prev_tail),
  .ext_word_valid(ext_word_valid), .rpt_valid(rpt_valid), .rpt(rpt),
  .rpt_base_pc(rpt_base_pc), .ov_prev(ov_prev), .ov_next(ov_next),
  .total_clks(total_clks), .prefetch_early(prefetch_early), .ext_wait(ext_wait)
);
`default_nettype wire

//--- eats_bus_model.sv
// Purpose: Bus controller delivering the extension word into the pipe
// Assumes: fetch_clks is the access time in clocks
// Notes: Word vanishes once the fetch is withdrawn
`timescale 1ns/10ps
`default_nettype none
module eats_bus_model
  import eats_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Fetch from the bench
  input  wire logic       fetch_req,
  input  wire logic [3:0] fetch_clks,
  // Extension word in the pipe
  output var logic        ext_word_valid
);
  logic [3:0] cnt_r;

  // Saturates so a long stall never wraps into a false arrival
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 4'h0;
    end else if (!fetch_req) begin
      cnt_r <= 4'h0;
    end else if (cnt_r != 4'hf) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  always_comb begin
    ext_word_valid = fetch_req && (cnt_r >= fetch_clks);
  end
endmodule : eats_bus_model
`default_nettype wire

//--- test_ea_timing_sequencer.sv
// Purpose: Self-checking bench for the effective-address timing sequencer
// Assumes: Inputs change on the falling edge of mclk
// Notes: Overlap arithmetic is also watched by the bound checker
`timescale 1ns/10ps
`default_nettype none
module test_ea_timing_sequencer
  import eats_pkg::*;
;
  logic              mclk, reset_n, req_valid, req_ready, ext_word_valid;
  logic              rpt_valid, rpt_base_pc, prefetch_early, ext_wait, fetch_req;
  eats_req_s         req;
  eats_fig_s         rpt;
  logic [4:0]        next_head, ov_prev, ov_next;
  logic signed [6:0] prev_tail;
  logic [7:0]        total_clks;
  logic [3:0]        fetch_clks;
  logic              early, wseen;
  int                n_mismatch, tests_run, lat;
  eats_req_s         r;

  // mode, calc, long, pc, bus | prev tail, next head | head, tail, cycles, reads, fetches | ovp, ovn, total
  int tbl[9][15] = '{
    '{EATS_FULL_D32ANX, 0, 0, 0, 2, 0, 0, 1, 3,  9, 1, 3, 0, 0,  9},
    '{EATS_FULL_D16ANX, 0, 0, 0, 2, 0, 4, 2, 2,  8, 1, 2, 0, 2,  6},
    '{EATS_FULL_D32ANX, 1, 0, 0, 2, 2, 1, 1, 1,  7, 0, 3, 1, 1,  5},
    '{EATS_FULL_D32ANX, 0, 1, 0, 2, 0, 9, 1, 5, 11, 2, 3, 0, 5,  6},
    '{EATS_FULL_D32ANX, 0, 0, 1, 2, 0, 0, 1, 3,  9, 1, 3, 0, 0,  9},
    '{EATS_FULL_D32ANX, 0, 0, 0, 3, 0, 0, 0, 6, 12, 1, 3, 0, 0, 12},
    '{EATS_FULL_D16ANX, 0, 0, 0, 4, 0, 3, 0, 6, 12, 1, 2, 0, 3,  9},
    '{EATS_D8X,         0, 0, 0, 2, 4, 0, 4, 2,  8, 1, 1, 4, 0,  4},
    '{EATS_IND,         1, 1, 0, 2, 0, 0, 1, 0,  2, 0, 0, 0, 0,  2}
  };

  eats_seq eats_seq_inst (
    .mclk(mclk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .next_head(next_head), .prev_tail(prev_tail),
    .ext_word_valid(ext_word_valid), .rpt_valid(rpt_valid), .rpt(rpt),
    .rpt_base_pc(rpt_base_pc), .ov_prev(ov_prev), .ov_next(ov_next),
    .total_clks(total_clks), .prefetch_early(prefetch_early), .ext_wait(ext_wait)
  );

  eats_bus_model eats_bus_model_inst (
    .mclk(mclk), .reset_n(reset_n), .fetch_req(fetch_req),
    .fetch_clks(fetch_clks), .ext_word_valid(ext_word_valid)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk

  // Holds the request until taken, then waits a bounded time for the report
  task automatic go(input eats_req_s q, input logic signed [6:0] pt, input logic [4:0] nh,
                    input logic fr);
    int n;
    n = 0;
    wseen = 1'b0;
    @(negedge mclk);
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    req_valid = 1'b1;
    req = q;
    prev_tail = pt;
    next_head = nh;
    fetch_req = fr;
    @(posedge mclk);
    #1;
    early = prefetch_early;
    @(negedge mclk);
    req_valid = 1'b0;
    lat = 0;
    while (rpt_valid !== 1'b1 && lat < 50) begin
      if (ext_wait === 1'b1) wseen = 1'b1;
      @(negedge mclk);
      lat++;
    end
    fetch_req = 1'b0;
    if (n >= 50 || lat >= 50) begin
      n_mismatch++;
      $display("unexpected at %0t: timeout", $time);
      end_sim();
    end
  endtask : go

  task automatic row(input int t[15]);
    eats_req_s q;
    eats_fig_s f;
    q = '{eats_mode_e'(t[0]), t[1][0], t[2][0], t[3][0], 4'(t[4]), 1'b0, 1'b0};
    f = '{5'(t[7]), 7'(t[8]), 7'(t[9]), 2'(t[10]), 2'(t[11]), 2'h0};
    go(q, 7'(t[5]), 5'(t[6]), 1'b0);
    chk(rpt === f, "figures");
    chk(ov_prev === 5'(t[12]) && ov_next === 5'(t[13]), "overlap");
    chk(total_clks === 8'(t[14]) && rpt_base_pc === q.base_pc, "total");
    chk(lat == 2, "latency");
  endtask : row

  initial begin
    {reset_n, req_valid, fetch_req} = '0;
    {req, next_head, prev_tail, early, wseen} = '0;
    fetch_clks = 4'h6;
    n_mismatch = 0;
    tests_run = 0;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1'b1;
    foreach (tbl[i]) begin
      row(tbl[i]);
    end
    r = '{EATS_IND, 1'b0, 1'b0, 1'b0, 4'h2, 1'b0, 1'b0};
    go(r, -7'sh2, 5'h1, 1'b0);
    chk(early === 1'b1 && ov_prev === 5'h0, "early prefetch");
    r.ext_imm = 1'b1;
    go(r, 7'sh0, 5'h0, 1'b1);
    chk(wseen === 1'b1 && lat > 5, "extension wait");
    r.ext_long = 1'b1;
    go(r, 7'sh0, 5'h0, 1'b0);
    chk(lat == 2 && wseen === 1'b0, "long extension no wait");
    @(negedge mclk);
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    reset_n = 1'b0;
    #1;
    chk(req_ready === 1'b1 && rpt_valid === 1'b0 && rpt === EATS_FIG_RST, "reset");
    @(negedge mclk);
    reset_n = 1'b1;
    row(tbl[1]);
    end_sim();
  end
endmodule : test_ea_timing_sequencer
`default_nettype wire
